// *** rtl/txabr_pkg.sv ***
package txabr_pkg;

  // Register byte offsets
  localparam logic [7:0] TXABR_CTRL_OFS     = 8'h00;
  localparam logic [7:0] TXABR_STATUS_OFS   = 8'h04;
  localparam logic [7:0] TXABR_MASK_OFS     = 8'h08;
  localparam logic [7:0] TXABR_INFO_LO_OFS  = 8'h0C;
  localparam logic [7:0] TXABR_INFO_HI_OFS  = 8'h10;
  localparam logic [7:0] TXABR_IREG_OFS     = 8'h14;
  localparam logic [7:0] TXABR_POST_OFS     = 8'h18;
  localparam logic [7:0] TXABR_XCODE_OFS    = 8'h1C;
  localparam logic [7:0] TXABR_ACNT_OFS     = 8'h20;
  localparam logic [7:0] TXABR_BSEL_OFS     = 8'h24;
  localparam logic [7:0] TXABR_BFROM_OFS    = 8'h28;
  localparam logic [7:0] TXABR_BTO_OFS      = 8'h2C;

  // Control bit positions
  localparam int TXABR_CTRL_EN      = 0;
  localparam int TXABR_CTRL_SAMPLE  = 1;
  localparam int TXABR_CTRL_BTR_EN  = 2;
  localparam int TXABR_CTRL_CSTACK  = 3;
  localparam logic [3:0] TXABR_CTRL_RST = 4'h0;

  // Status and mask bit positions
  localparam int TXABR_ST_REC     = 0;
  localparam int TXABR_ST_ABORT   = 1;
  localparam int TXABR_ST_XABORT  = 2;
  localparam int TXABR_ST_STALE   = 3;
  localparam int TXABR_ST_W       = 4;
  localparam logic [3:0] TXABR_ST_RST = 4'h0;

  // Abort information field layout (64 bits)
  localparam int TXABR_INFO_W       = 64;
  localparam int TXABR_CYC_W        = 32;
  localparam int TXABR_BIT_INSTR    = 34;
  localparam int TXABR_BIT_NONINSTR = 35;
  localparam int TXABR_BIT_CONFLICT = 37;
  localparam int TXABR_BIT_CAP_WR   = 38;
  localparam int TXABR_BIT_CAP_RD   = 39;

  // Accumulator layout handed to the fallback path
  localparam int TXABR_ACC_EXPLICIT = 0;
  localparam int TXABR_ACC_CODE_LSB = 24;
  localparam int TXABR_CODE_W       = 8;

  // Software abort code convention
  localparam logic [7:0] TXABR_CODE_LOCK_BUSY  = 8'hFF;
  localparam logic [7:0] TXABR_CODE_LOCK_TEST  = 8'hFE;
  localparam logic [7:0] TXABR_CODE_NEST_TRY   = 8'hFD;
  localparam logic [7:0] TXABR_CODE_RSVD_HI    = 8'hFC;
  localparam logic [7:0] TXABR_CODE_RSVD_LO    = 8'hF0;

  // Recorder state
  typedef enum logic [1:0] {TXABR_IDLE, TXABR_IN_TX, TXABR_RECORD} txabr_state_t;

endpackage : txabr_pkg

// *** rtl/txabr_recorder.sv ***
// Contract
// - Abort info low 32 bits hold cycles spent in last region before abort.
// - Instruction-attributable abort sets bit 34 and records that instruction address.
// - Exceptions inside a region count as instruction-attributed aborts.
// - Abort not attributable to the reported address sets bit 35 instead.
// - Data conflict abort sets bit 37 together with bit 35.
// - Write-set overflow sets bit 38, read-set overflow sets bit 39.
// - Explicit abort operand goes to accumulator for fallback and into record.
// - Any interrupt taken inside a region aborts the region.
// - Sampled abort records post-abort pointer and in-region pointer.
// - Non-abort samples inside a region report the same two pointers; here any sample inside a region aborts it.
// - Branch trace recording keeps working across regions and aborts.
// - Call-stack trace mode may be inconsistent after aborts.
//
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none

module txabr_recorder
  import txabr_pkg::*;
#(
  parameter int PTR_W     = 32,
  parameter int BTR_DEPTH = 8
)(
  input  wire logic                     clk,
  input  wire logic                     sys_rst,
  // Core transactional machinery
  input  wire logic                     tx_begin,
  input  wire logic                     tx_commit,
  input  wire logic                     abort_instr,
  input  wire logic                     abort_exception,
  input  wire logic                     abort_conflict,
  input  wire logic                     abort_cap_write,
  input  wire logic                     abort_cap_read,
  input  wire logic                     abort_explicit,
  input  wire logic [TXABR_CODE_W-1:0]  explicit_code,
  input  wire logic                     irq_taken,
  input  wire logic                     sample_event,
  input  wire logic [PTR_W-1:0]         in_region_pointer,
  input  wire logic [PTR_W-1:0]         abort_handler_pointer,
  // Branch trace source
  input  wire logic                     branch_valid,
  input  wire logic                     branch_is_call,
  input  wire logic                     branch_is_ret,
  input  wire logic [PTR_W-1:0]         branch_from,
  input  wire logic [PTR_W-1:0]         branch_to,
  // Fallback path
  output logic                          fallback_go,
  output logic [31:0]                   accumulator_register,
  output logic [PTR_W-1:0]              post_abort_pointer,
  // Precise sample record and open-region flag
  output logic                          record_valid,
  output logic [TXABR_INFO_W-1:0]       record_info,
  output logic [PTR_W-1:0]              record_in_region,
  output logic [PTR_W-1:0]              record_post_abort,
  output logic [31:0]                   record_accum,
  output logic                          in_region,
  // Register port
  input  wire logic [7:0]               reg_addr,
  input  wire logic [31:0]              reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic [31:0]                   reg_rdata,
  output logic                          irq
);

  localparam int BIDX_W = (BTR_DEPTH > 1) ? $clog2(BTR_DEPTH) : 1;

  // Builds the accumulator word for the fallback path
  function automatic logic [31:0] acc_word(input logic expl, input logic [TXABR_CODE_W-1:0] code);
    logic [31:0] w;
    w = 32'h0;
    w[TXABR_ACC_EXPLICIT] = expl;
    w[TXABR_ACC_CODE_LSB +: TXABR_CODE_W] = expl ? code : 8'h00;
    return w;
  endfunction : acc_word

  // Registers
  txabr_state_t                   state_q, state_d;
  logic                           in_region_q;
  logic [TXABR_CYC_W-1:0]         cyc_q;
  logic [3:0]                     ctrl_q;
  logic [TXABR_ST_W-1:0]          status_q;
  logic [TXABR_ST_W-1:0]          mask_q;
  logic [31:0]                    acnt_q;
  logic [BIDX_W-1:0]              bwr_q;
  logic [BIDX_W-1:0]              bsel_q;
  logic [7:0]                     cdepth_q;
  logic [PTR_W-1:0]               bfrom_mem [BTR_DEPTH];
  logic [PTR_W-1:0]               bto_mem   [BTR_DEPTH];
  logic                           fallback_go_q;
  logic [31:0]                    acc_q;
  logic [PTR_W-1:0]               post_q;
  logic                           rec_valid_q;
  logic [TXABR_INFO_W-1:0]        rec_info_q;
  logic [PTR_W-1:0]               rec_ireg_q;
  logic [PTR_W-1:0]               rec_post_q;
  logic [31:0]                    rec_acc_q;
  logic [31:0]                    rdata_q;
  logic                           irq_q;

  // Control decode
  wire en_w       = ctrl_q[TXABR_CTRL_EN];
  wire sample_w   = ctrl_q[TXABR_CTRL_SAMPLE];
  wire btr_en_w   = ctrl_q[TXABR_CTRL_BTR_EN];
  wire cstack_w   = ctrl_q[TXABR_CTRL_CSTACK];
  wire in_tx_w    = (state_q == TXABR_IN_TX);

  // Abort sources; any interrupt or sample inside a region aborts it
  wire core_abort = abort_instr | abort_exception | abort_conflict
                  | abort_cap_write | abort_cap_read | abort_explicit;
  wire abort_now  = en_w & in_tx_w & (core_abort | irq_taken | sample_event);
  wire sample_out = en_w & sample_w & sample_event & ~in_tx_w;

  // Cause classification; instruction-attributed wins over the others
  wire instr_attr = abort_instr | abort_exception | abort_explicit;
  wire cause_conf = ~instr_attr & abort_conflict;
  wire cause_cw   = ~instr_attr & abort_cap_write;
  wire cause_cr   = ~instr_attr & abort_cap_read;
  wire non_instr  = ~instr_attr;

  // Whole abort information word, written at once
  logic [TXABR_INFO_W-1:0] info_w;
  always_comb
  begin
    info_w = '0;
    info_w[TXABR_CYC_W-1:0]        = cyc_q;
    info_w[TXABR_BIT_INSTR]        = instr_attr;
    info_w[TXABR_BIT_NONINSTR]     = non_instr;
    info_w[TXABR_BIT_CONFLICT]     = cause_conf;
    info_w[TXABR_BIT_CAP_WR]       = cause_cw;
    info_w[TXABR_BIT_CAP_RD]       = cause_cr;
  end

  wire [31:0] acc_w = acc_word(abort_explicit & instr_attr, explicit_code);

  // Region state machine
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      TXABR_IDLE:
        if (en_w && tx_begin)
          state_d = TXABR_IN_TX;
      TXABR_IN_TX:
        if (abort_now)
          state_d = TXABR_RECORD;
        else if (tx_commit || !en_w)
          state_d = TXABR_IDLE;
      TXABR_RECORD:
        state_d = TXABR_IDLE;
      default:
        state_d = TXABR_IDLE;
    endcase
  end

  // State register, with a registered copy of the open-region flag for the output
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_q     <= TXABR_IDLE;
      in_region_q <= 1'b0;
    end
    else
    begin
      state_q     <= state_d;
      in_region_q <= (state_d == TXABR_IN_TX);
    end
  end

  // Cycle count of the current region, saturating
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      cyc_q <= '0;
    else if (state_q != TXABR_IN_TX)
      cyc_q <= '0;
    else if (cyc_q != {TXABR_CYC_W{1'b1}})
      cyc_q <= cyc_q + 1'b1;
  end

  // Fallback delivery of the accumulator and handler pointer
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      fallback_go_q <= 1'b0;
      acc_q         <= '0;
      post_q        <= '0;
    end
    else
    begin
      fallback_go_q <= abort_now;
      if (abort_now)
      begin
        acc_q  <= acc_w;
        post_q <= abort_handler_pointer;
      end
    end
  end

  // Sample record capture
  wire rec_take = abort_now & sample_w;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rec_valid_q <= 1'b0;
      rec_info_q  <= '0;
      rec_ireg_q  <= '0;
      rec_post_q  <= '0;
      rec_acc_q   <= '0;
    end
    else
    begin
      rec_valid_q <= rec_take | sample_out;
      if (rec_take)
      begin
        rec_info_q <= info_w;
        rec_ireg_q <= in_region_pointer;
        rec_post_q <= abort_handler_pointer;
        rec_acc_q  <= acc_w;
      end
      else if (sample_out)
      begin
        rec_info_q <= '0;
        rec_ireg_q <= in_region_pointer;
        rec_post_q <= in_region_pointer;
        rec_acc_q  <= '0;
      end
    end
  end

  // Branch trace ring; runs regardless of region state
  wire btr_push = btr_en_w & branch_valid;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      bwr_q <= '0;
    else if (btr_push)
      bwr_q <= (bwr_q == BIDX_W'(BTR_DEPTH - 1)) ? '0 : bwr_q + 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (btr_push)
    begin
      bfrom_mem[bwr_q] <= branch_from;
      bto_mem[bwr_q]   <= branch_to;
    end
  end

  // Call depth tracking; the abort does not unwind calls made inside the region, only a later return does
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      cdepth_q <= '0;
    else if (btr_push && cstack_w && branch_is_call && cdepth_q != 8'hFF)
      cdepth_q <= cdepth_q + 1'b1;
    else if (btr_push && cstack_w && branch_is_ret && cdepth_q != 8'h00)
      cdepth_q <= cdepth_q - 1'b1;
  end

  wire stale_ev = abort_now & cstack_w & (cdepth_q != 8'h00);

  // Register decode
  wire wr_ctrl   = reg_wr & (reg_addr == TXABR_CTRL_OFS);
  wire wr_status = reg_wr & (reg_addr == TXABR_STATUS_OFS);
  wire wr_mask   = reg_wr & (reg_addr == TXABR_MASK_OFS);
  wire wr_bsel   = reg_wr & (reg_addr == TXABR_BSEL_OFS);

  // Event bits; a set in the clearing cycle wins
  wire [TXABR_ST_W-1:0] ev_w = {stale_ev, abort_now & abort_explicit, abort_now, rec_take | sample_out};
  wire [TXABR_ST_W-1:0] clr_w = wr_status ? reg_wdata[TXABR_ST_W-1:0] : '0;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ctrl_q   <= TXABR_CTRL_RST;
      status_q <= TXABR_ST_RST;
      mask_q   <= TXABR_ST_RST;
      bsel_q   <= '0;
      irq_q    <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= reg_wdata[3:0];
      if (wr_mask)
        mask_q <= reg_wdata[TXABR_ST_W-1:0];
      if (wr_bsel)
        bsel_q <= reg_wdata[BIDX_W-1:0];
      status_q <= (status_q & ~clr_w) | ev_w;
      irq_q    <= |(((status_q & ~clr_w) | ev_w) & (wr_mask ? reg_wdata[TXABR_ST_W-1:0] : mask_q));
    end
  end

  // Abort counter
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      acnt_q <= '0;
    else if (abort_now)
      acnt_q <= acnt_q + 1'b1;
  end

  // Read mux
  logic [31:0] rmux_w;
  always_comb
  begin
    rmux_w = 32'h0;
    case (reg_addr)
      TXABR_CTRL_OFS:    rmux_w = {28'h0, ctrl_q};
      TXABR_STATUS_OFS:  rmux_w = {{(32-TXABR_ST_W){1'b0}}, status_q};
      TXABR_MASK_OFS:    rmux_w = {{(32-TXABR_ST_W){1'b0}}, mask_q};
      TXABR_INFO_LO_OFS: rmux_w = rec_info_q[31:0];
      TXABR_INFO_HI_OFS: rmux_w = rec_info_q[63:32];
      TXABR_IREG_OFS:    rmux_w = 32'(rec_ireg_q);
      TXABR_POST_OFS:    rmux_w = 32'(rec_post_q);
      TXABR_XCODE_OFS:   rmux_w = rec_acc_q;
      TXABR_ACNT_OFS:    rmux_w = acnt_q;
      TXABR_BSEL_OFS:    rmux_w = 32'(bsel_q);
      TXABR_BFROM_OFS:   rmux_w = 32'(bfrom_mem[bsel_q]);
      TXABR_BTO_OFS:     rmux_w = 32'(bto_mem[bsel_q]);
      default:           rmux_w = 32'h0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      rdata_q <= '0;
    else
      rdata_q <= reg_rd ? rmux_w : 32'h0;
  end

  // Outputs straight from flip-flops
  assign fallback_go          = fallback_go_q;
  assign accumulator_register = acc_q;
  assign post_abort_pointer   = post_q;
  assign record_valid         = rec_valid_q;
  assign record_info          = rec_info_q;
  assign record_in_region     = rec_ireg_q;
  assign record_post_abort    = rec_post_q;
  assign record_accum         = rec_acc_q;
  assign in_region            = in_region_q;
  assign reg_rdata            = rdata_q;
  assign irq                  = irq_q;

endmodule : txabr_recorder

`default_nettype wire

// *** bench/txabr_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module txabr_checker #(
  parameter int PTR_W = 32
)(
  input wire logic             clk,
  input wire logic             sys_rst,
  input wire logic             in_region,
  input wire logic             abort_instr,
  input wire logic             abort_exception,
  input wire logic             abort_conflict,
  input wire logic             abort_cap_write,
  input wire logic             abort_cap_read,
  input wire logic             abort_explicit,
  input wire logic [7:0]       explicit_code,
  input wire logic             irq_taken,
  input wire logic             sample_event,
  input wire logic [PTR_W-1:0] in_region_pointer,
  input wire logic [PTR_W-1:0] abort_handler_pointer,
  input wire logic             fallback_go,
  input wire logic [31:0]      accumulator_register,
  input wire logic [PTR_W-1:0] post_abort_pointer,
  input wire logic             record_valid,
  input wire logic [63:0]      record_info,
  input wire logic [PTR_W-1:0] record_in_region,
  input wire logic [PTR_W-1:0] record_post_abort,
  input wire logic             irq
);
  logic        ev;
  logic        ai;
  logic [31:0] cyc_q;
  // Any abort trigger, and the instruction-attributed subset
  assign ev = abort_instr | abort_exception | abort_conflict | abort_cap_write | abort_cap_read
              | abort_explicit | irq_taken | sample_event;
  assign ai = abort_instr | abort_exception | abort_explicit;
  // Cycles the region has been open, zero on its first cycle
  always_ff @(posedge clk) cyc_q <= (sys_rst || !in_region) ? 32'h0 : cyc_q + 32'h1;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_abort_ends: assert property (
    in_region && ev |=> fallback_go && !in_region && post_abort_pointer == $past(abort_handler_pointer))
    else $error("abort did not close the region");
  a_instr_class: assert property (
    in_region && ev && ai ##1 record_valid |-> record_info[34] && !record_info[35])
    else $error("instruction abort misclassified");
  a_noninstr_bits: assert property (
    in_region && ev && !ai ##1 record_valid |->
      record_info[35] && !record_info[34]
      && record_info[39:37] == $past({abort_cap_read, abort_cap_write, abort_conflict}))
    else $error("non-instruction cause bits wrong");
  a_zero_bits: assert property (
    record_valid |-> record_info[63:40] == 24'h0 && !record_info[36] && record_info[33:32] == 2'h0)
    else $error("undescribed cause bit set");
  a_cycle_count: assert property (
    in_region && ev ##1 record_valid |-> record_info[31:0] == $past(cyc_q))
    else $error("region cycle count wrong");
  a_explicit_code: assert property (
    in_region && abort_explicit |=> accumulator_register == {$past(explicit_code), 23'h0, 1'b1})
    else $error("explicit operand not delivered");
  a_plain_acc: assert property (
    in_region && ev && !abort_explicit |=> accumulator_register == 32'h0)
    else $error("accumulator not clear for implicit abort");
  a_two_pointers: assert property (
    in_region && ev ##1 record_valid |-> record_in_region == $past(in_region_pointer)
      && record_post_abort == $past(abort_handler_pointer))
    else $error("record pointers wrong");
  c_instr: cover property (record_valid && record_info[34]);
  c_conflict: cover property (record_valid && record_info[37]);
  c_irq: cover property (irq);
endmodule : txabr_checker

bind txabr_recorder txabr_checker #(.PTR_W(PTR_W)) i_chk (
  .clk, .sys_rst, .in_region, .abort_instr, .abort_exception, .abort_conflict,
  .abort_cap_write, .abort_cap_read, .abort_explicit, .explicit_code, .irq_taken,
  .sample_event, .in_region_pointer, .abort_handler_pointer, .fallback_go,
  .accumulator_register, .post_abort_pointer, .record_valid, .record_info,
  .record_in_region, .record_post_abort, .irq
);
`default_nettype wire

// *** bench/txabr_sw_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module txabr_sw_model (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        record_valid,
  output logic      [15:0] rec_count
);
  logic [15:0] count_q;
  // Profiling side takes each record in its one flagged cycle
  always_ff @(posedge clk)
  begin
    count_q <= sys_rst ? 16'h0 : count_q + {15'h0, record_valid};
  end
  assign rec_count = count_q;
endmodule : txabr_sw_model
`default_nettype wire

// *** bench/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
  import txabr_pkg::*;
  logic        clk, sys_rst, tx_begin, tx_commit, irq_taken, sample_event;
  logic        reg_wr, reg_rd, fallback_go, record_valid, in_region, irq;
  logic [5:0]  cause;
  logic [7:0]  explicit_code, reg_addr;
  logic [31:0] in_ptr, hnd_ptr, post_ptr, rec_in, rec_post;
  logic [31:0] reg_wdata, reg_rdata, acc, rec_acc;
  logic [63:0] record_info;
  logic        branch_valid, branch_is_call, branch_is_ret;
  logic [31:0] branch_from, branch_to;
  logic [15:0] rec_count;
  logic [7:0]  cases [12] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h18, 8'h0C, 8'h20, 8'h20, 8'h20, 8'h40, 8'h80};
  logic [7:0]  codes [3] = '{TXABR_CODE_LOCK_BUSY, TXABR_CODE_LOCK_TEST, TXABR_CODE_NEST_TRY};
  int          bad_count, checks_done;

  txabr_recorder #(.PTR_W(32), .BTR_DEPTH(8)) i_dut (
    .clk, .sys_rst, .tx_begin, .tx_commit, .abort_instr(cause[0]), .abort_exception(cause[1]),
    .abort_conflict(cause[2]), .abort_cap_write(cause[3]), .abort_cap_read(cause[4]),
    .abort_explicit(cause[5]), .explicit_code, .irq_taken, .sample_event,
    .in_region_pointer(in_ptr), .abort_handler_pointer(hnd_ptr), .branch_valid,
    .branch_is_call, .branch_is_ret, .branch_from, .branch_to,
    .fallback_go, .accumulator_register(acc), .post_abort_pointer(post_ptr), .record_valid,
    .record_info, .record_in_region(rec_in), .record_post_abort(rec_post), .record_accum(rec_acc),
    .in_region, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq);
  txabr_sw_model i_sw (.clk, .sys_rst, .record_valid, .rec_count);

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask : rd

  // Open a region, abort it after n cycles with the given triggers, check what comes out
  task region(input int n, input logic [7:0] c, input logic [7:0] code);
    logic [63:0] exp;
    logic [31:0] ea;
    exp = (c[0] | c[1] | c[5]) ? 64'h0000_0004_0000_0000 : {24'h0, c[4], c[3], c[2], 5'h08, 32'h0};
    exp[31:0] = n;
    ea = c[5] ? {code, 23'h0, 1'b1} : 32'h0;
    @(posedge clk);
    tx_begin <= 1'b1;
    @(posedge clk);
    tx_begin <= 1'b0;
    repeat (n) @(posedge clk);
    {sample_event, irq_taken, cause} <= c;
    explicit_code <= code;
    in_ptr <= 32'h1000 + n;
    hnd_ptr <= 32'h2000 + n;
    @(posedge clk);
    {sample_event, irq_taken, cause} <= 8'h0;
    #1;
    chk({in_region, fallback_go, record_valid}, 3'h3);
    chk(record_info, exp);
    chk({rec_in, rec_post}, {in_ptr, hnd_ptr});
    chk(post_ptr, hnd_ptr);
    chk({acc, rec_acc}, {ea, ea});
  endtask : region

  task finish_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test

  initial
  begin
    #(50 * 3000);
    bad_count++;
    finish_test();
  end

  initial
  begin
    {sys_rst, tx_begin, tx_commit, irq_taken, sample_event, cause} = 11'h400;
    {reg_wr, reg_rd, reg_addr, reg_wdata, explicit_code, in_ptr, hnd_ptr} = '0;
    {branch_valid, branch_is_call, branch_is_ret, branch_from, branch_to} = '0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    // Ring entries come out of reset undefined, so only the first ten offsets are read
    for (int i = 0; i < 10; i++) rd(8'h00 + 8'(4 * i), 32'h0);
    rd(8'h40, 32'h0);
    wr(TXABR_CTRL_OFS, 32'h7);
    rd(TXABR_CTRL_OFS, 32'h7);
    wr(TXABR_MASK_OFS, 32'h3);
    // Every cause, every code, cycle counts from zero upward
    foreach (cases[i]) region(i, cases[i], codes[i % 3]);
    rd(TXABR_INFO_LO_OFS, 32'd11);
    rd(TXABR_INFO_HI_OFS, 32'h8);
    rd(TXABR_ACNT_OFS, 32'd12);
    chk(rec_count, 16'd12);
    chk(irq, 1'b1);
    rd(TXABR_STATUS_OFS, 32'h7);
    wr(TXABR_MASK_OFS, 32'h0);
    @(posedge clk);
    #1;
    chk(irq, 1'b0);
    wr(TXABR_MASK_OFS, 32'h3);
    wr(TXABR_STATUS_OFS, 32'hF);
    @(posedge clk);
    #1;
    chk(irq, 1'b0);
    rd(TXABR_STATUS_OFS, 32'h0);
    // Call left open by an abort marks the call stack stale; the ring keeps its entries
    wr(TXABR_CTRL_OFS, 32'hF);
    @(posedge clk);
    {branch_valid, branch_is_call, branch_from, branch_to} <= {2'h3, 32'h3000, 32'h3100};
    @(posedge clk);
    branch_valid <= 1'b0;
    region(2, 8'h04, 8'h00);
    rd(TXABR_STATUS_OFS, 32'hB);
    rd(TXABR_BFROM_OFS, 32'h3000);
    rd(TXABR_BTO_OFS, 32'h3100);
    // Return unwinds the depth, so the next abort leaves the call stack clean
    @(posedge clk);
    {branch_valid, branch_is_call, branch_is_ret, branch_from, branch_to} <= {3'h5, 32'h3200, 32'h3300};
    @(posedge clk);
    {branch_valid, branch_is_ret} <= 2'h0;
    wr(TXABR_STATUS_OFS, 32'hF);
    region(1, 8'h08, 8'h00);
    rd(TXABR_STATUS_OFS, 32'h3);
    wr(TXABR_BSEL_OFS, 32'h1);
    rd(TXABR_BFROM_OFS, 32'h3200);
    rd(TXABR_BTO_OFS, 32'h3300);
    // Commit, then triggers while no region is open
    @(posedge clk);
    tx_begin <= 1'b1;
    @(posedge clk);
    {tx_begin, tx_commit} <= 2'h1;
    @(posedge clk);
    {tx_commit, cause} <= 7'h04;
    @(posedge clk);
    {cause, sample_event} <= 7'h01;
    #1;
    chk({in_region, fallback_go, record_valid}, 3'h0);
    @(posedge clk);
    sample_event <= 1'b0;
    #1;
    chk({fallback_go, record_valid}, 2'h1);
    chk(record_info, 64'h0);
    finish_test();
  end
endmodule : tb
`default_nettype wire
